// file: haptic_ctrl_asserts.sv
// checker: timing relations of the haptic power, mode and fire control
`timescale 1ns/1ps
module haptic_ctrl_asserts
  import haptic_ctrl_pkg::*;
(
  input wire logic       sys_clk,                // clock
  input wire logic       rst_n,                  // reset, active low
  input wire logic       enable_pin,             // enable pin
  input wire logic       out_short_det,          // output short
  input wire reg_write_t host_wr,                // host write
  input wire logic [7:0] mode_rd,                // control byte
  input wire logic [7:0] status_rd,              // status byte
  input wire logic       fire_signal,            // internal fire
  input wire launch_t    launch,                 // launch lines
  input wire logic       drive_en,               // drive enable
  input wire pwr_state_t pwr_state,              // power state
  input wire logic       output_overcurrent_flag // short flag
);
  logic [3:0] en_hist;
  logic       mode_wr;
  logic       busy;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // writes only count once enable has passed the synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      en_hist <= 4'h0;
    else
      en_hist <= {en_hist[2:0], enable_pin};
  end
  // accepted control write and any running process
  assign mode_wr = host_wr.wr && host_wr.addr == MODE_OFFSET &&
                   (&en_hist) && enable_pin;
  assign busy = launch.playback | launch.calib | launch.diag |
                launch.continuous;
  a_mode_write_lands: assert property (
    mode_wr && !host_wr.data[7] |-> ##2 {mode_rd[6], mode_rd[2:0]} ==
      $past({host_wr.data[6], host_wr.data[2:0]}, 2))
    else $error("control byte did not follow write");
  a_soft_reset_defaults: assert property (
    mode_wr && host_wr.data[7] |-> ##[1:8] mode_rd == 8'h40)
    else $error("soft reset left no defaults");
  a_disabled_reads_zero: assert property (
    !enable_pin [*5] |-> mode_rd == 8'h00 && status_rd == 8'h00)
    else $error("read data while enable low");
  a_shutdown_no_drive: assert property (
    pwr_state == PWR_SHUTDOWN [*2] |-> !drive_en)
    else $error("drive on in shutdown");
  a_standby_stops_all: assert property (
    pwr_state == PWR_STANDBY [*2] |-> !busy)
    else $error("process running in standby");
  a_launch_needs_fire: assert property (
    $rose(launch.playback) |-> fire_signal)
    else $error("playback without fire");
  a_short_only_busy: assert property (
    $rose(output_overcurrent_flag) |->
      busy || $past(busy, 1) || $past(busy, 2))
    else $error("short flagged while idle");
  a_flag_holds: assert property (
    output_overcurrent_flag && out_short_det |=> output_overcurrent_flag)
    else $error("short flag dropped with short present");
  c_play: cover property ($rose(launch.playback));
  c_short: cover property ($rose(output_overcurrent_flag));
  c_soft: cover property (mode_wr && host_wr.data[7]);
endmodule : haptic_ctrl_asserts

bind haptic_power_mode_fire_control haptic_ctrl_asserts u_asserts (
  .sys_clk(sys_clk), .rst_n(rst_n), .enable_pin(enable_pin),
  .out_short_det(out_short_det), .host_wr(host_wr), .mode_rd(mode_rd),
  .status_rd(status_rd), .fire_signal(fire_signal), .launch(launch),
  .drive_en(drive_en), .pwr_state(pwr_state),
  .output_overcurrent_flag(output_overcurrent_flag));

// file: haptic_ctrl_pkg.sv
// package: constants and carriers for haptic power, mode and fire control
package haptic_ctrl_pkg;

  // register offsets and field positions of the control group
  localparam logic [7:0] STATUS_OFFSET   = 8'h00;
  localparam logic [7:0] MODE_OFFSET     = 8'h01;
  localparam logic [7:0] SEQ_FIRST_OFF   = 8'h04;
  localparam logic [7:0] SEQ_LAST_OFF    = 8'h0B;
  localparam logic [7:0] FIRE_OFFSET     = 8'h0C;
  localparam logic [7:0] FIRE_WRITE_VAL  = 8'h01;
  localparam int         STANDBY_BIT_POS = 6;
  localparam int         RESET_BIT_POS   = 7;

  // values after reset
  localparam logic [2:0] MODE_RESET      = 3'h0;
  localparam logic       STANDBY_RESET   = 1'b1;
  localparam logic       N_PWM_RESET     = 1'b0;
  localparam logic       OL_RESET        = 1'b0;

  // cycles a soft reset holds the block in its default state
  localparam int         SOFT_RESET_CYCLES = 4;

  typedef enum logic [2:0] {
    MODE_INT_TRIG   = 3'h0,
    MODE_EDGE_TRIG  = 3'h1,
    MODE_LEVEL_TRIG = 3'h2,
    MODE_ANALOG_PWM = 3'h3,
    MODE_AUDIO_VIBE = 3'h4,
    MODE_REALTIME   = 3'h5,
    MODE_DIAG       = 3'h6,
    MODE_CALIB      = 3'h7
  } op_mode_t;

  typedef enum logic [1:0] {
    PWR_SHUTDOWN = 2'h0,
    PWR_STANDBY  = 2'h1,
    PWR_READY    = 2'h2,
    PWR_ACTIVE   = 2'h3
  } pwr_state_t;

  // register write strobe from the host interface
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  // process launch outputs
  typedef struct packed {
    logic playback;
    logic calib;
    logic diag;
    logic continuous;
  } launch_t;

  // decoded view of the mode field
  function automatic logic is_continuous(input logic [2:0] m);
    is_continuous = (m == MODE_ANALOG_PWM) || (m == MODE_AUDIO_VIBE) ||
                    (m == MODE_REALTIME);
  endfunction : is_continuous

  function automatic logic is_ext_trig(input logic [2:0] m);
    is_ext_trig = (m == MODE_EDGE_TRIG) || (m == MODE_LEVEL_TRIG);
  endfunction : is_ext_trig

endpackage : haptic_ctrl_pkg

// file: haptic_host_model.sv
// host side model: register writes, enable and trigger pins
`timescale 1ns/1ps
module haptic_host_model
  import haptic_ctrl_pkg::*;
(
  input  wire logic  sys_clk,          // clock
  output reg_write_t host_wr,          // write strobe
  output logic       enable_pin,       // enable drive
  output logic       input_trigger_pin // trigger drive
);
  // idle bus, device disabled
  initial begin
    host_wr = '0;
    enable_pin = 1'b0;
    input_trigger_pin = 1'b0;
  end
  // one write, strobe held for exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    host_wr <= {1'b1, a, d};
    @(posedge sys_clk);
    #1;
    host_wr <= '0;
  endtask : wr
  // pin levels, called just after an edge
  task automatic pins(input logic e, input logic t);
    enable_pin <= e;
    input_trigger_pin <= t;
  endtask : pins
endmodule : haptic_host_model

// file: haptic_power_mode_fire_control.sv
// power states, soft reset, mode decode and fire signal of a haptic driver
//
// Contract
// - regulator short keeps device dead; removal restores all defaults
// - brownout shuts down and resets; recovery comes back in default state
// - enable pin low is shutdown with registers kept; high allows operation
// - enable low: no register read or write; host keeps enable high
// - standby bit at 0x01 set after reset; standby keeps registers, access
// - setting standby stops any playback at once
// - clearing standby moves device to ready state
// - soft reset bit aborts playback, restores defaults, then clears itself
// - active processes start only on internal fire signal, not the bit
// - short before playback blocks it until mode field rewritten
// - mode field decodes eight modes; mode 3 split by pwm-not-analog bit
// - fire bit launches sequence, or calibration/diagnostics in those modes
// - internal mode: 0x01 to 0x0C sets fire bit until sequence ends
// - host clearing fire bit during playback cancels the remaining sequence
// - external trigger modes drive fire bit from trigger input
// - continuous modes assert internal fire but leave fire bit unchanged
// - open-loop mode toggles output at open-loop rate regardless of load
// - output short in playback sets overcurrent flag, cuts drive
// - short checking only while a process runs; idle shorts go unseen
// - edge mode: rising edge sets fire bit, another rising edge cancels
// - level mode: fire bit follows trigger pin, falling edge cancels
// - overcurrent and over-temperature flags readable in status at 0x00
//
// notes
// - pins pass two flops, so every pin effect lags by two cycles
// - a write in the cycle enable falls can still land, since the
//   enable level is seen two cycles late
// - set beats clear on the fire bit; a trigger edge is never lost
// - the short block is cleared by any control write, so a same-value
//   mode rewrite is enough to resume playback
// - the pwm-not-analog setting only picks the input path, which lives
//   outside this block; it does not change firing here
// - readback is forced to zero while enable is low, like a device
//   that acknowledges but transfers nothing
// - over-temperature is reported only; it does not stop playback here
// - soft reset holds the internal reset for a fixed number of cycles
// - open-loop ticks come from an outside divider as one-cycle pulses
`timescale 1ns/1ps
module haptic_power_mode_fire_control
  import haptic_ctrl_pkg::*;
(
  input  wire logic       sys_clk,          // 200 MHz system clock
  input  wire logic       rst_n,            // power-on reset, active low
  input  wire logic       brownout_det,     // brownout comparator, pin
  input  wire logic       reg_short_det,    // regulator short sense, pin
  input  wire logic       enable_pin,       // enable pin, high = operate
  input  wire logic       input_trigger_pin,// external trigger pin
  input  wire logic       out_short_det,    // output short sense, pin
  input  wire logic       over_temp_det,    // over-temperature sense, pin
  input  wire logic       seq_done,         // sequencer finished, pulse
  input  wire logic       proc_done,        // calib/diag finished, pulse
  input  wire logic       open_loop_tick,   // open-loop half-period pulse
  input  wire reg_write_t host_wr,          // host register write
  input  wire logic       n_pwm_analog_in,  // pwm-not-analog setting
  input  wire logic       open_loop_in,     // lra open-loop setting
  output logic [7:0]      status_rd,        // status byte for 0x00
  output logic [7:0]      mode_rd,          // control byte for 0x01
  output logic            fire_bit_rd,      // fire bit as seen at 0x0C
  output logic            fire_signal,      // internal fire signal
  output launch_t         launch,           // process launch lines
  output logic            drive_en,         // output stage enable
  output logic            drive_phase,      // output polarity
  output pwr_state_t      pwr_state,        // current power state
  output logic            output_overcurrent_flag // output short flag
);

  // synchronised pin levels
  logic bo_lvl, rs_lvl, en_lvl, sh_lvl, ot_lvl;
  logic trig_lvl, trig_rise;

  // trigger pin gets its own synchroniser for edge pulses
  trig_sync u_trig (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .pin_in   (input_trigger_pin),
    .level_out(trig_lvl),
    .rise_out (trig_rise),
    .fall_out ()
  );

  // level pins share one bundle so they all see the same latency
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;

  // plain two-flop synchronisers for the level inputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
    end else begin
      meta_reg <= {brownout_det, reg_short_det, enable_pin,
                   out_short_det, over_temp_det};
      sync_reg <= meta_reg;
    end
  end
  assign {bo_lvl, rs_lvl, en_lvl, sh_lvl, ot_lvl} = sync_reg;

  // internal reset: faults hold it, soft reset stretches it
  logic [2:0] sreset_cnt_reg;
  logic       soft_req;
  logic       int_reset;
  logic       acc_ok;

  assign acc_ok    = en_lvl;

  // accepted host write to one offset; enable gates every access
  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = acc_ok && host_wr.wr && host_wr.addr == off;
  endfunction : wr_hit

  assign soft_req  = wr_hit(MODE_OFFSET) && host_wr.data[RESET_BIT_POS];
  assign int_reset = bo_lvl || rs_lvl || (sreset_cnt_reg != 3'h0);

  // soft reset counter; reloads if the host writes the bit again
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sreset_cnt_reg <= 3'h0;
    end else if (soft_req) begin
      sreset_cnt_reg <= 3'(SOFT_RESET_CYCLES);
    end else if (sreset_cnt_reg != 3'h0) begin
      sreset_cnt_reg <= sreset_cnt_reg - 3'h1;
    end
  end

  // control register fields
  logic [2:0] mode_reg;
  logic       standby_reg;
  logic       mode_wr;

  assign mode_wr = wr_hit(MODE_OFFSET) && !host_wr.data[RESET_BIT_POS];

  // faults and soft reset win over any host write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg    <= MODE_RESET;
      standby_reg <= STANDBY_RESET;
    end else if (int_reset) begin
      mode_reg    <= MODE_RESET;
      standby_reg <= STANDBY_RESET;
    end else if (mode_wr) begin
      mode_reg    <= host_wr.data[2:0];
      standby_reg <= host_wr.data[STANDBY_BIT_POS];
    end
  end

  // power state: enable low is shutdown, registers untouched
  pwr_state_t state_next;
  logic       busy;

  // shutdown outranks standby, standby outranks activity
  always_comb begin
    if (!en_lvl || int_reset) begin
      state_next = PWR_SHUTDOWN;
    end else if (standby_reg) begin
      state_next = PWR_STANDBY;
    end else if (busy) begin
      state_next = PWR_ACTIVE;
    end else begin
      state_next = PWR_READY;
    end
  end

  // registered so the state output comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_state <= PWR_SHUTDOWN;
    end else begin
      pwr_state <= state_next;
    end
  end

  // running: enabled, awake and out of any reset
  logic running;
  assign running = en_lvl && !standby_reg && !int_reset;

  // fire bit: host writes, trigger pin and completion
  logic fire_reg;
  logic fire_wr;
  logic fire_set, fire_clr;

  assign fire_wr = wr_hit(FIRE_OFFSET);

  // per-mode set and clear terms for the fire bit
  always_comb begin
    fire_set = 1'b0;
    fire_clr = 1'b0;
    unique case (mode_reg)
      MODE_EDGE_TRIG: begin
        fire_set = trig_rise && !fire_reg;
        fire_clr = trig_rise && fire_reg;
      end
      MODE_LEVEL_TRIG: begin
        fire_set = trig_lvl;
        fire_clr = !trig_lvl;
      end
      MODE_ANALOG_PWM, MODE_AUDIO_VIBE, MODE_REALTIME: begin
        fire_set = 1'b0;
      end
      default: begin
        fire_set = fire_wr && host_wr.data == FIRE_WRITE_VAL;
      end
    endcase
    if (fire_wr && host_wr.data == 8'h00) begin
      fire_clr = 1'b1;
    end
    if ((seq_done || proc_done) && fire_reg) begin
      fire_clr = 1'b1;
    end
  end

  // set beats clear in the same cycle so a trigger is never lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_reg <= 1'b0;
    end else if (int_reset || standby_reg) begin
      fire_reg <= 1'b0;
    end else if (fire_set) begin
      fire_reg <= 1'b1;
    end else if (fire_clr) begin
      fire_reg <= 1'b0;
    end
  end

  // short bookkeeping: latched flag and playback block
  logic sc_block_reg;
  assign busy = running && (fire_reg || is_continuous(mode_reg));

  // flag clears once the short is gone, whatever the state, or on any internal reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_overcurrent_flag <= 1'b0;
    end else if (int_reset) begin
      output_overcurrent_flag <= 1'b0;
    end else if (busy && sh_lvl) begin
      output_overcurrent_flag <= 1'b1;
    end else if (!sh_lvl) begin
      output_overcurrent_flag <= 1'b0;
    end
  end

  // short first seen while a process runs, at its start or mid-run, blocks playback until a mode rewrite
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_block_reg <= 1'b0;
    end else if (int_reset || mode_wr) begin
      sc_block_reg <= 1'b0;
    end else if (busy && sh_lvl && !output_overcurrent_flag) begin
      sc_block_reg <= 1'b1;
    end
  end

  // internal fire and process launches
  // a blocked playback keeps its fire bit but never fires
  logic fire_next;
  assign fire_next = running && !sc_block_reg &&
                     (fire_reg || is_continuous(mode_reg));

  // launches follow fire in the same cycle; each is a registered level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_signal <= 1'b0;
      launch      <= '0;
    end else begin
      fire_signal         <= fire_next;
      launch.playback     <= fire_next && !is_continuous(mode_reg) &&
                             mode_reg != MODE_CALIB &&
                             mode_reg != MODE_DIAG;
      launch.calib        <= fire_next && mode_reg == MODE_CALIB;
      launch.diag         <= fire_next && mode_reg == MODE_DIAG;
      launch.continuous   <= fire_next && is_continuous(mode_reg);
    end
  end

  // drive stage: off on short, toggles on open-loop tick
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_en    <= 1'b0;
      drive_phase <= 1'b0;
    end else begin
      drive_en <= fire_next && !sh_lvl;
      // phase restarts at zero on every new launch
      if (!fire_next) begin
        drive_phase <= 1'b0;
      end else if (open_loop_in && open_loop_tick) begin
        drive_phase <= ~drive_phase;
      end
    end
  end

  // readback; zero while enable is low since no read is possible
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_rd   <= 8'h00;
      mode_rd     <= 8'h00;
      fire_bit_rd <= 1'b0;
    end else begin
      status_rd   <= acc_ok ? {6'h00, output_overcurrent_flag, ot_lvl}
                            : 8'h00;
      mode_rd     <= acc_ok ? {1'b0, standby_reg, 3'h0, mode_reg} : 8'h00;
      fire_bit_rd <= acc_ok && fire_reg;
    end
  end

endmodule : haptic_power_mode_fire_control

// file: haptic_power_mode_fire_control_tb_top.sv
// testbench: power states, soft reset, modes and fire
`timescale 1ns/1ps
module haptic_power_mode_fire_control_tb_top
  import haptic_ctrl_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       brownout_det = 1'b0;
  logic       reg_short_det = 1'b0;
  logic       out_short_det = 1'b0;
  logic       over_temp_det = 1'b0;
  logic       seq_done = 1'b0;
  logic       proc_done = 1'b0;
  logic       ol_tick = 1'b0;
  logic       ol_en = 1'b0;
  logic       phase;
  reg_write_t host_wr;
  logic       enable_pin;
  logic       input_trigger_pin;
  logic [7:0] status_rd;
  logic [7:0] mode_rd;
  logic       fire_bit_rd;
  logic       fire_signal;
  logic       drive_en;
  logic       flag;
  launch_t    launch;
  pwr_state_t pwr_state;
  int         fails = 0;
  int         check_count = 0;
  int         cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  haptic_host_model u_host (.sys_clk(sys_clk), .host_wr(host_wr),
    .enable_pin(enable_pin), .input_trigger_pin(input_trigger_pin));

  haptic_power_mode_fire_control u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .brownout_det(brownout_det), .reg_short_det(reg_short_det),
    .enable_pin(enable_pin), .input_trigger_pin(input_trigger_pin),
    .out_short_det(out_short_det), .over_temp_det(over_temp_det),
    .seq_done(seq_done), .proc_done(proc_done), .open_loop_tick(ol_tick),
    .host_wr(host_wr), .n_pwm_analog_in(1'b0), .open_loop_in(ol_en),
    .status_rd(status_rd), .mode_rd(mode_rd), .fire_bit_rd(fire_bit_rd),
    .fire_signal(fire_signal), .launch(launch), .drive_en(drive_en),
    .drive_phase(phase), .pwr_state(pwr_state),
    .output_overcurrent_flag(flag));

  // hang guard, far above the length of all scenarios
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  task automatic done_pulse;
    seq_done = 1'b1;
    w(1);
    seq_done = 1'b0;
  endtask : done_pulse

  task automatic t_fire;
    u_host.wr(MODE_OFFSET, 8'h00);
    w(3);
    chk({6'h0, pwr_state}, {6'h0, PWR_READY});
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    w(3);
    chk({5'h0, fire_bit_rd, fire_signal, launch.playback}, 8'h07);
    done_pulse();
    w(3);
    chk({6'h0, fire_bit_rd, fire_signal}, 8'h00);
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    u_host.wr(FIRE_OFFSET, 8'h00);
    w(3);
    chk({7'h0, launch.playback}, 8'h00);
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    u_host.wr(MODE_OFFSET, 8'h40);
    w(2);
    chk({7'h0, launch.playback}, 8'h00);
    u_host.wr(FIRE_OFFSET, 8'h00);
  endtask : t_fire

  // every mode code; continuous ones fire without the bit
  task automatic t_modes;
    for (int m = 0; m < 8; m++) begin
      u_host.wr(MODE_OFFSET, 8'(m));
      w(3);
      chk(mode_rd, 8'(m));
      chk({6'h0, fire_bit_rd, fire_signal},
          (m > 2 && m < 6) ? 8'h01 : 8'h00);
      if (m == 5) begin
        ol_en = 1'b1;
        ol_tick = 1'b1;
        w(1);
        ol_tick = 1'b0;
        w(2);
        chk({5'h0, launch.continuous, drive_en, phase}, 8'h07);
        chk({6'h0, pwr_state}, {6'h0, PWR_ACTIVE});
        ol_en = 1'b0;
      end
      if (m > 5) begin
        u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
        w(3);
        chk({6'h0, launch.calib, launch.diag}, m == 7 ? 8'h02 : 8'h01);
        proc_done = 1'b1;
        w(1);
        proc_done = 1'b0;
        w(3);
        chk({7'h0, fire_bit_rd}, 8'h00);
        u_host.wr(FIRE_OFFSET, 8'h00);
      end
    end
  endtask : t_modes

  task automatic t_trig;
    u_host.wr(MODE_OFFSET, 8'h01);
    for (int i = 0; i < 2; i++) begin
      u_host.pins(1'b1, 1'b1);
      w(2);
      u_host.pins(1'b1, 1'b0);
      w(5);
      chk({7'h0, fire_bit_rd}, i == 0 ? 8'h01 : 8'h00);
    end
    u_host.wr(MODE_OFFSET, 8'h02);
    u_host.pins(1'b1, 1'b1);
    w(5);
    chk({7'h0, fire_bit_rd}, 8'h01);
    u_host.pins(1'b1, 1'b0);
    w(5);
    chk({7'h0, fire_bit_rd}, 8'h00);
  endtask : t_trig

  task automatic t_enable;
    u_host.wr(MODE_OFFSET, 8'h05);
    u_host.pins(1'b0, 1'b0);
    w(6);
    chk(mode_rd, 8'h00);
    chk({6'h0, pwr_state}, {6'h0, PWR_SHUTDOWN});
    u_host.wr(MODE_OFFSET, 8'h02);
    u_host.pins(1'b1, 1'b0);
    w(6);
    chk(mode_rd, 8'h05);
  endtask : t_enable

  // idle short unseen, then seen by a process and blocking replay
  task automatic t_short;
    u_host.wr(MODE_OFFSET, 8'h00);
    out_short_det = 1'b1;
    w(6);
    chk({7'h0, flag}, 8'h00);
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    w(6);
    chk({6'h0, flag, status_rd[1]}, 8'h03);
    out_short_det = 1'b0;
    u_host.wr(FIRE_OFFSET, 8'h00);
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    w(4);
    chk({7'h0, launch.playback}, 8'h00);
    u_host.wr(FIRE_OFFSET, 8'h00);
    u_host.wr(MODE_OFFSET, 8'h00);
    u_host.wr(FIRE_OFFSET, FIRE_WRITE_VAL);
    w(4);
    chk({7'h0, launch.playback}, 8'h01);
    done_pulse();
    over_temp_det = 1'b1;
    w(5);
    chk({7'h0, status_rd[0]}, 8'h01);
    over_temp_det = 1'b0;
  endtask : t_short

  task automatic t_soft;
    u_host.wr(MODE_OFFSET, 8'h05);
    u_host.wr(MODE_OFFSET, 8'h80);
    w(8);
    chk(mode_rd, 8'h40);
    u_host.wr(MODE_OFFSET, 8'h02);
    w(3);
    chk(mode_rd, 8'h02);
  endtask : t_soft

  // brownout then regulator short, each a full internal reset
  task automatic t_resets;
    for (int i = 0; i < 2; i++) begin
      u_host.wr(MODE_OFFSET, 8'h03);
      w(3);
      {brownout_det, reg_short_det} = i == 0 ? 2'b10 : 2'b01;
      w(6);
      chk({6'h0, pwr_state}, {6'h0, PWR_SHUTDOWN});
      {brownout_det, reg_short_det} = 2'b00;
      w(8);
      chk(mode_rd, 8'h40);
    end
  endtask : t_resets

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  initial begin
    u_host.pins(1'b1, 1'b0);
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    w(4);
    chk(mode_rd, 8'h40);
    t_fire();
    t_modes();
    t_trig();
    t_enable();
    t_short();
    t_soft();
    t_resets();
    results();
  end
endmodule : haptic_power_mode_fire_control_tb_top

// file: trig_sync.sv
// two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module trig_sync (
  input  wire logic sys_clk,    // system clock
  input  wire logic rst_n,      // async reset, active low
  input  wire logic pin_in,     // raw pin level
  output logic      level_out,  // synchronised level
  output logic      rise_out,   // one-cycle rising edge
  output logic      fall_out    // one-cycle falling edge
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // first stage feeds only the second; edges look at later stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
  assign fall_out  = ~sync_reg & prev_reg;

endmodule : trig_sync
